// [include/core_flags_pkg.sv]
// Package with constants and types of the core status flag register
package core_flags_pkg;

   //------------------------------------------------------------
   // Register layout
   //------------------------------------------------------------
   localparam int           FLAG_W     = 8;
   localparam int           TO_BIT     = 4;
   localparam int           PD_BIT     = 3;
   localparam int           Z_BIT      = 2;
   localparam int           DC_BIT     = 1;
   localparam int           C_BIT      = 0;
   localparam logic [1:0]   CAUSE_RESET = 2'h3;
   localparam logic [2:0]   ARITH_RESET = 3'h0;
   localparam logic [2:0]   UPPER_ZERO  = 3'h0;

   //------------------------------------------------------------
   // APB map
   //------------------------------------------------------------
   localparam int           APB_ADDR_W     = 8;
   localparam logic [7:0]   OFF_FLAGS      = 8'h00;
   localparam logic [7:0]   OFF_IRQ_STATUS = 8'h04;
   localparam logic [7:0]   OFF_IRQ_MASK   = 8'h08;
   localparam logic [7:0]   OFF_RESULT     = 8'h0C;
   localparam logic [31:0]  RD_ZERO        = 32'h0000_0000;

   //------------------------------------------------------------
   // Interrupt events
   //------------------------------------------------------------
   localparam int           EV_W        = 3;
   localparam int           EV_TIMEOUT  = 0;
   localparam int           EV_SLEEP    = 1;
   localparam int           EV_BLOCKED  = 2;
   localparam logic [2:0]   EV_RESET    = 3'h0;

   //------------------------------------------------------------
   // Operations
   //------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CLEAR,
      OP_ROTR, OP_ROTL, OP_SWAP, OP_BCLR, OP_BSET
   } alu_op_t;

   typedef logic [2:0] affect_t;

endpackage

// [include/flag_alu_if.sv]
// Interface between the flag register core and its ALU
`timescale 1ns/100ps
interface flag_alu_if;
   core_flags_pkg::alu_op_t  op;
   logic [2:0]               bit_sel;
   logic [7:0]               operand_a;
   logic [7:0]               operand_b;
   logic                     carry_in;
   logic [7:0]               result;
   logic [2:0]               flags;
   core_flags_pkg::affect_t  affect;

   modport alu  (input op, bit_sel, operand_a, operand_b, carry_in,
                 output result, flags, affect);
   modport core (output op, bit_sel, operand_a, operand_b, carry_in,
                 input result, flags, affect);
endinterface

// [rtl/flag_alu.sv]
// Combinational ALU producing result, flag values and affected-flag mask
`timescale 1ns/100ps
module flag_alu (
   flag_alu_if.alu  fa
);

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y, input logic cin);
      add9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
   endfunction

   function automatic logic nib_carry(input logic [7:0] x, input logic [7:0] y, input logic cin);
      logic [4:0] s;
      s = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      nib_carry = s[4];
   endfunction

   //------------------------------------------------------------
   // Datapath
   //------------------------------------------------------------
   always_comb begin
      logic [8:0] sum;
      sum       = 9'h000;
      fa.result = fa.operand_a;
      fa.flags  = 3'h0;
      fa.affect = 3'h0;
      case (fa.op)
         core_flags_pkg::OP_ADD: begin
            sum       = add9(fa.operand_a, fa.operand_b, 1'b0);
            fa.result = sum[7:0];
            fa.flags  = {sum[7:0] == 8'h00, nib_carry(fa.operand_a, fa.operand_b, 1'b0),
                         sum[8]};
            fa.affect = 3'h7;
         end
         core_flags_pkg::OP_SUB: begin
            // Operand b minus operand a as b plus the complement of a plus one
            sum       = add9(fa.operand_b, ~fa.operand_a, 1'b1);
            fa.result = sum[7:0];
            fa.flags  = {sum[7:0] == 8'h00, nib_carry(fa.operand_b, ~fa.operand_a, 1'b1), sum[8]};
            fa.affect = 3'h7;
         end
         core_flags_pkg::OP_AND,
         core_flags_pkg::OP_OR,
         core_flags_pkg::OP_XOR,
         core_flags_pkg::OP_CLEAR: begin
            if (fa.op == core_flags_pkg::OP_AND) begin
               fa.result = fa.operand_a & fa.operand_b;
            end else if (fa.op == core_flags_pkg::OP_OR) begin
               fa.result = fa.operand_a | fa.operand_b;
            end else if (fa.op == core_flags_pkg::OP_XOR) begin
               fa.result = fa.operand_a ^ fa.operand_b;
            end else begin
               fa.result = 8'h00;
            end
            fa.flags  = {fa.result == 8'h00, 2'h0};
            fa.affect = 3'h4;
         end
         core_flags_pkg::OP_ROTR: begin
            fa.result = {fa.carry_in, fa.operand_b[7:1]};
            fa.flags  = {2'h0, fa.operand_b[0]};
            fa.affect = 3'h1;
         end
         core_flags_pkg::OP_ROTL: begin
            fa.result = {fa.operand_b[6:0], fa.carry_in};
            fa.flags  = {2'h0, fa.operand_b[7]};
            fa.affect = 3'h1;
         end
         core_flags_pkg::OP_SWAP: fa.result = {fa.operand_b[3:0], fa.operand_b[7:4]};
         core_flags_pkg::OP_BCLR: fa.result = fa.operand_b & ~(8'h01 << fa.bit_sel);
         core_flags_pkg::OP_BSET: fa.result = fa.operand_b | (8'h01 << fa.bit_sel);
         default:                 fa.result = fa.operand_a;
      endcase
   end

endmodule // flag_alu

// [rtl/core_status_flag_register.sv]
// Processor status flag register with flag update logic and APB access
//------------------------------------------------------------
// Summary of operation
// - Flag register accepted as any instruction destination
// - Affected flag bits come from logic, not write
// - Software writes never change reset-cause flags
// - Bits seven to five read as zero
// - Timeout flag set by power-up, clear, sleep
// - Powerdown flag set by power-up, cleared by sleep
// - Zero flag reflects arithmetic or logic zero result
// - Nibble carry from bit three carry-out
// - Carry flag from most significant bit carry-out
// - Subtraction carry flags mean no borrow when one
// - Subtract by adding two's complement of operand
// - Rotates load carry with shifted-out bit
// - Clear on flags sets zero, keeps others
`timescale 1ns/100ps
module core_status_flag_register (
   input  wire logic                       core_clk,
   input  wire logic                       nrst,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       instr_valid,
   input  wire core_flags_pkg::alu_op_t    instr_op,
   input  wire logic [7:0]                 work_value,
   input  wire logic [7:0]                 file_value,
   input  wire logic [2:0]                 bit_sel,
   input  wire logic                       dest_flags,
   input  wire logic                       watchdog_clear_instr,
   input  wire logic                       powerdown_instr,
   input  wire logic                       watchdog_timeout,
   output logic      [7:0]                 result,
   output logic                            result_valid,
   output logic      [7:0]                 flags_out,
   output logic                            irq
);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   logic [2:0]             arith_flags;
   logic [1:0]             cause_flags;
   logic [7:0]             last_result;
   logic [2:0]             irq_status;
   logic [2:0]             irq_mask;
   logic [2:0]             next_arith;
   logic [1:0]             next_cause;
   logic [2:0]             next_status;
   logic [2:0]             next_mask;
   logic                   access;
   logic                   wr_fire;
   logic                   wr_flags;
   logic                   wr_status;
   logic                   wr_mask;
   logic                   blocked;
   logic [2:0]             events;

   flag_alu_if fa ();

   flag_alu u_alu (
      .fa (fa)
   );

   //------------------------------------------------------------
   // Address decode
   //------------------------------------------------------------
   function automatic logic addr_hit(input logic [7:0] a);
      if (a == core_flags_pkg::OFF_FLAGS) begin
         addr_hit = 1'b1;
      end else if (a == core_flags_pkg::OFF_IRQ_STATUS) begin
         addr_hit = 1'b1;
      end else if (a == core_flags_pkg::OFF_IRQ_MASK) begin
         addr_hit = 1'b1;
      end else if (a == core_flags_pkg::OFF_RESULT) begin
         addr_hit = 1'b1;
      end else begin
         addr_hit = 1'b0;
      end
   endfunction

   //------------------------------------------------------------
   // ALU operands
   //------------------------------------------------------------
   // With the flag register as destination it is also the source
   assign fa.op        = instr_op;
   assign fa.bit_sel   = bit_sel;
   assign fa.operand_a = work_value;
   assign fa.operand_b = dest_flags ? flags_out : file_value;
   assign fa.carry_in  = arith_flags[core_flags_pkg::C_BIT];

   //------------------------------------------------------------
   // APB slave, one wait state
   //------------------------------------------------------------
   assign access    = psel & penable;
   assign wr_fire   = access & pready & pwrite & ~pslverr;
   assign wr_flags  = wr_fire & (paddr == core_flags_pkg::OFF_FLAGS);
   assign wr_status = wr_fire & (paddr == core_flags_pkg::OFF_IRQ_STATUS);
   assign wr_mask   = wr_fire & (paddr == core_flags_pkg::OFF_IRQ_MASK);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prdata  <= core_flags_pkg::RD_ZERO;
         pslverr <= 1'b0;
      end else if (access & ~pready) begin
         pslverr <= ~addr_hit(paddr);
         if (pwrite) begin
            prdata <= core_flags_pkg::RD_ZERO;
         end else if (paddr == core_flags_pkg::OFF_FLAGS) begin
            prdata <= {24'h00_0000, flags_out};
         end else if (paddr == core_flags_pkg::OFF_IRQ_STATUS) begin
            prdata <= {29'h0000_0000, irq_status};
         end else if (paddr == core_flags_pkg::OFF_IRQ_MASK) begin
            prdata <= {29'h0000_0000, irq_mask};
         end else if (paddr == core_flags_pkg::OFF_RESULT) begin
            prdata <= {24'h00_0000, last_result};
         end else begin
            prdata <= core_flags_pkg::RD_ZERO;
         end
      end else begin
         prdata  <= core_flags_pkg::RD_ZERO;
         pslverr <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Arithmetic flags
   //------------------------------------------------------------
   // An instruction in the same cycle wins over a bus write; the
   // bus can never reach the reset-cause bits
   always_comb begin
      next_arith = arith_flags;
      if (instr_valid) begin
         for (int i = 0; i < 3; i++) begin
            if (fa.affect[i]) begin
               next_arith[i] = fa.flags[i];
            end else if (dest_flags && (fa.affect == 3'h0)) begin
               next_arith[i] = fa.result[i];
            end else begin
               next_arith[i] = arith_flags[i];
            end
         end
      end else if (wr_flags) begin
         next_arith = pwdata[2:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         arith_flags <= core_flags_pkg::ARITH_RESET;
      end else begin
         arith_flags <= next_arith;
      end
   end

   //------------------------------------------------------------
   // Reset-cause flags
   //------------------------------------------------------------
   // Only hardware events reach these; instruction results and
   // bus writes never do. A timeout wins over a same-cycle clear.
   always_comb begin
      next_cause = cause_flags;
      if (watchdog_clear_instr) begin
         next_cause = 2'h3;
      end
      if (powerdown_instr) begin
         next_cause = 2'h2;
      end
      if (watchdog_timeout) begin
         next_cause[1] = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cause_flags <= core_flags_pkg::CAUSE_RESET;
      end else begin
         cause_flags <= next_cause;
      end
   end

   assign flags_out = {core_flags_pkg::UPPER_ZERO, cause_flags, arith_flags};

   //------------------------------------------------------------
   // Instruction result
   //------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         last_result  <= 8'h00;
         result_valid <= 1'b0;
      end else begin
         result_valid <= instr_valid;
         if (instr_valid) begin
            last_result <= fa.result;
         end
      end
   end

   assign result = last_result;

   //------------------------------------------------------------
   // Interrupts
   //------------------------------------------------------------
   assign blocked        = instr_valid & dest_flags & (fa.affect != 3'h0);
   assign events         = {blocked, powerdown_instr, watchdog_timeout};

   // A new event beats a write-one-to-clear in the same cycle
   always_comb begin
      next_status = irq_status;
      if (wr_status) begin
         next_status = irq_status & ~pwdata[2:0];
      end
      next_status = next_status | events;
      next_mask   = wr_mask ? pwdata[2:0] : irq_mask;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq_status <= core_flags_pkg::EV_RESET;
      end else begin
         irq_status <= next_status;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq_mask <= core_flags_pkg::EV_RESET;
      end else begin
         irq_mask <= next_mask;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & next_mask);
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   logic [8:0] chk_sum;
   logic [4:0] chk_nib;
   assign chk_sum = {1'b0, work_value} + {1'b0, file_value};
   assign chk_nib = {1'b0, work_value[3:0]} + {1'b0, file_value[3:0]};

   sequence no_cause_event;
      !watchdog_clear_instr && !powerdown_instr && !watchdog_timeout;
   endsequence

   sequence flags_read_done;
      access && pready && !pwrite && (paddr == core_flags_pkg::OFF_FLAGS);
   endsequence

   sequence plain_instr(core_flags_pkg::alu_op_t o);
      instr_valid && (instr_op == o) && !dest_flags;
   endsequence

   sequence flags_move;
      instr_valid && dest_flags && (instr_op == core_flags_pkg::OP_MOVE);
   endsequence

   reset_value_a: assert property (disable iff (1'b0) !nrst |=> flags_out == 8'h18)
      else $error("flag register reset value wrong");

   upper_zero_a: assert property (flags_read_done |-> prdata[31:5] == 27'h000_0000)
      else $error("upper flag bits read nonzero");

   timeout_clr_a: assert property (watchdog_timeout |=> !flags_out[core_flags_pkg::TO_BIT])
      else $error("timeout flag not cleared by watchdog timeout");

   sleep_flags_a: assert property (powerdown_instr && !watchdog_timeout |=> flags_out[4:3] == 2'h2)
      else $error("sleep did not set timeout and clear powerdown");

   wdt_clear_a: assert property (watchdog_clear_instr && !powerdown_instr && !watchdog_timeout
                                 |=> flags_out[4:3] == 2'h3)
      else $error("watchdog clear did not set cause flags");

   cause_hold_a: assert property (no_cause_event |=> flags_out[4:3] == $past(flags_out[4:3]))
      else $error("cause flags changed without a hardware event");

   sw_write_a: assert property (wr_flags && !instr_valid ##0 no_cause_event
                                |=> flags_out[4:3] == $past(flags_out[4:3])
                                    && flags_out[2:0] == $past(pwdata[2:0]))
      else $error("bus write to flag register wrong");

   zero_flag_a: assert property (instr_valid && (instr_op == core_flags_pkg::OP_XOR)
                                 |=> flags_out[2] == (result == 8'h00))
      else $error("zero flag disagrees with result");

   add_carry_a: assert property (plain_instr(core_flags_pkg::OP_ADD)
                                 |=> flags_out[0] == $past(chk_sum[8]))
      else $error("add carry wrong");

   add_nibble_a: assert property (plain_instr(core_flags_pkg::OP_ADD)
                                  |=> flags_out[1] == $past(chk_nib[4]))
      else $error("add nibble carry wrong");

   sub_borrow_a: assert property (plain_instr(core_flags_pkg::OP_SUB)
                                  |=> flags_out[1:0] == {$past(file_value[3:0] >= work_value[3:0]),
                                                         $past(file_value >= work_value)})
      else $error("subtract borrow flags wrong");

   sub_result_a: assert property (plain_instr(core_flags_pkg::OP_SUB)
                                  |=> result == $past(file_value - work_value))
      else $error("subtract result wrong");

   rotate_carry_a: assert property (plain_instr(core_flags_pkg::OP_ROTR)
                                    |=> flags_out[0] == $past(file_value[0])
                                        && flags_out[2:1] == $past(flags_out[2:1]))
      else $error("rotate right carry wrong");

   rotate_left_a: assert property (plain_instr(core_flags_pkg::OP_ROTL)
                                   |=> flags_out[0] == $past(file_value[7]))
      else $error("rotate left carry wrong");

   clear_dest_a: assert property (instr_valid && dest_flags && (instr_op == core_flags_pkg::OP_CLEAR)
                                  |=> flags_out[2] && flags_out[1:0] == $past(flags_out[1:0]))
      else $error("clear on flag register wrong");

   move_dest_a: assert property (flags_move |=> flags_out[2:0] == $past(work_value[2:0]))
      else $error("move to flag register lost the written bits");

   ready_pulse_a: assert property (pready |=> !pready)
      else $error("bus ready held longer than one cycle");

   irq_level_a: assert property (irq == |(irq_status & irq_mask))
      else $error("interrupt level does not match status and mask");

endmodule // core_status_flag_register

// [testbench/testbench.sv]
// Self-checking testbench of the core status flag register
`timescale 1ns/100ps
module testbench;
   logic                    core_clk;
   logic                    nrst;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [7:0]              paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic                    instr_valid;
   core_flags_pkg::alu_op_t instr_op;
   logic [7:0]              work_value;
   logic [7:0]              file_value;
   logic [2:0]              bit_sel;
   logic                    dest_flags;
   logic                    watchdog_clear_instr;
   logic                    powerdown_instr;
   logic                    watchdog_timeout;
   logic [7:0]              result;
   logic                    result_valid;
   logic [7:0]              flags_out;
   logic                    irq;
   int                      error_cnt;
   int                      checked;
   logic [31:0]             rd;
   logic                    err;

   core_status_flag_register i_core_status_flag_register (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr_op(instr_op), .work_value(work_value), .file_value(file_value),
      .bit_sel(bit_sel), .dest_flags(dest_flags), .watchdog_clear_instr(watchdog_clear_instr),
      .powerdown_instr(powerdown_instr), .watchdog_timeout(watchdog_timeout), .result(result),
      .result_valid(result_valid), .flags_out(flags_out), .irq(irq)
   );

   //------------------------------------------------------------
   // Clock and hang guard
   //------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   initial begin
      #2_000_000;
      error_cnt++;
      $display("ERROR at %0t: run did not finish in time", $time);
      print_verdict();
   end

   //------------------------------------------------------------
   // Shared tasks
   //------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // One APB transfer; waits for pready, takes data at that edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, addr, 32'h0000_0000);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, exp_err});
   endtask

   task automatic exec(input core_flags_pkg::alu_op_t op, input logic [7:0] w, input logic [7:0] f,
                       input logic [2:0] bs, input logic dst, input logic [7:0] exp_res,
                       input logic [7:0] exp_flg);
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr_op <= op;
      work_value <= w;
      file_value <= f;
      bit_sel <= bs;
      dest_flags <= dst;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      dest_flags <= 1'b0;
      @(negedge core_clk);
      chk({31'h0, result_valid}, 32'h0000_0001);
      chk({24'h0, result}, {24'h0, exp_res});
      chk({24'h0, flags_out}, {24'h0, exp_flg});
   endtask

   // Event pulse: 0 timeout, 1 sleep, 2 watchdog clear
   task automatic pulse(input int which, input logic [7:0] exp_flg);
      @(posedge core_clk);
      watchdog_timeout <= (which == 0);
      powerdown_instr <= (which == 1);
      watchdog_clear_instr <= (which == 2);
      @(posedge core_clk);
      watchdog_timeout <= 1'b0;
      powerdown_instr <= 1'b0;
      watchdog_clear_instr <= 1'b0;
      @(negedge core_clk);
      chk({24'h0, flags_out}, {24'h0, exp_flg});
   endtask

   task automatic irq_chk(input logic exp);
      @(posedge core_clk);
      @(negedge core_clk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   //------------------------------------------------------------
   // Test sequence
   //------------------------------------------------------------
   initial begin
      error_cnt = 0;
      checked = 0;
      nrst = 1'b0;
      {psel, penable, pwrite, instr_valid, dest_flags} = 5'h00;
      {watchdog_clear_instr, powerdown_instr, watchdog_timeout} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      instr_op = core_flags_pkg::OP_MOVE;
      {work_value, file_value, bit_sel} = 19'h0_0000;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      @(negedge core_clk);
      chk({24'h0, flags_out}, 32'h0000_0018);
      rd_chk(core_flags_pkg::OFF_FLAGS, 32'h0000_0018, 1'b0);
      rd_chk(core_flags_pkg::OFF_IRQ_STATUS, 32'h0000_0000, 1'b0);
      rd_chk(core_flags_pkg::OFF_IRQ_MASK, 32'h0000_0000, 1'b0);
      exec(core_flags_pkg::OP_ADD, 8'h0F, 8'h01, 3'h0, 1'b0, 8'h10, 8'h1A);
      exec(core_flags_pkg::OP_ADD, 8'h80, 8'h80, 3'h0, 1'b0, 8'h00, 8'h1D);
      exec(core_flags_pkg::OP_SUB, 8'h03, 8'h05, 3'h0, 1'b0, 8'h02, 8'h1B);
      exec(core_flags_pkg::OP_SUB, 8'h05, 8'h03, 3'h0, 1'b0, 8'hFE, 8'h18);
      exec(core_flags_pkg::OP_SUB, 8'h10, 8'h10, 3'h0, 1'b0, 8'h00, 8'h1F);
      exec(core_flags_pkg::OP_ROTL, 8'h00, 8'h40, 3'h0, 1'b0, 8'h81, 8'h1E);
      exec(core_flags_pkg::OP_ROTR, 8'h00, 8'h03, 3'h0, 1'b0, 8'h01, 8'h1F);
      exec(core_flags_pkg::OP_XOR, 8'hFF, 8'h0F, 3'h0, 1'b0, 8'hF0, 8'h1B);
      exec(core_flags_pkg::OP_AND, 8'h0F, 8'hF0, 3'h0, 1'b0, 8'h00, 8'h1F);
      exec(core_flags_pkg::OP_OR, 8'h01, 8'h00, 3'h0, 1'b0, 8'h01, 8'h1B);
      exec(core_flags_pkg::OP_MOVE, 8'h00, 8'h33, 3'h0, 1'b0, 8'h00, 8'h1B);
      exec(core_flags_pkg::OP_SWAP, 8'h00, 8'h12, 3'h0, 1'b0, 8'h21, 8'h1B);
      exec(core_flags_pkg::OP_BCLR, 8'h00, 8'hFF, 3'h3, 1'b0, 8'hF7, 8'h1B);
      exec(core_flags_pkg::OP_BSET, 8'h00, 8'h00, 3'h7, 1'b0, 8'h80, 8'h1B);
      exec(core_flags_pkg::OP_MOVE, 8'h07, 8'h00, 3'h0, 1'b1, 8'h07, 8'h1F);
      exec(core_flags_pkg::OP_MOVE, 8'hE0, 8'h00, 3'h0, 1'b1, 8'hE0, 8'h18);
      exec(core_flags_pkg::OP_BSET, 8'h00, 8'h00, 3'h0, 1'b1, 8'h19, 8'h19);
      exec(core_flags_pkg::OP_MOVE, 8'h01, 8'h00, 3'h0, 1'b1, 8'h01, 8'h19);
      exec(core_flags_pkg::OP_CLEAR, 8'h00, 8'h00, 3'h0, 1'b1, 8'h00, 8'h1D);
      exec(core_flags_pkg::OP_ADD, 8'h03, 8'h00, 3'h0, 1'b1, 8'h20, 8'h1A);
      rd_chk(core_flags_pkg::OFF_RESULT, 32'h0000_0020, 1'b0);
      apb(1'b1, core_flags_pkg::OFF_RESULT, 32'h0000_00FF);
      rd_chk(core_flags_pkg::OFF_RESULT, 32'h0000_0020, 1'b0);
      apb(1'b1, core_flags_pkg::OFF_FLAGS, 32'h0000_00E4);
      rd_chk(core_flags_pkg::OFF_FLAGS, 32'h0000_001C, 1'b0);
      apb(1'b1, core_flags_pkg::OFF_FLAGS, 32'h0000_0000);
      rd_chk(core_flags_pkg::OFF_FLAGS, 32'h0000_0018, 1'b0);
      rd_chk(8'h10, 32'h0000_0000, 1'b1);
      apb(1'b1, 8'h14, 32'h0000_00FF);
      chk({31'h0, err}, 32'h0000_0001);
      pulse(0, 8'h08);
      pulse(1, 8'h10);
      pulse(2, 8'h18);
      rd_chk(core_flags_pkg::OFF_IRQ_STATUS, 32'h0000_0007, 1'b0);
      @(negedge core_clk);
      chk({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, core_flags_pkg::OFF_IRQ_MASK, 32'h0000_0001);
      irq_chk(1'b1);
      apb(1'b1, core_flags_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
      irq_chk(1'b0);
      rd_chk(core_flags_pkg::OFF_IRQ_STATUS, 32'h0000_0006, 1'b0);
      apb(1'b1, core_flags_pkg::OFF_IRQ_MASK, 32'h0000_0007);
      irq_chk(1'b1);
      rd_chk(core_flags_pkg::OFF_IRQ_MASK, 32'h0000_0007, 1'b0);
      apb(1'b1, core_flags_pkg::OFF_IRQ_STATUS, 32'h0000_0006);
      irq_chk(1'b0);
      rd_chk(core_flags_pkg::OFF_IRQ_STATUS, 32'h0000_0000, 1'b0);
      // Second reset in mid-run restores the cause flags
      pulse(0, 8'h08);
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(negedge core_clk);
      chk({24'h0, flags_out}, 32'h0000_0018);
      chk({31'h0, irq}, 32'h0000_0000);
      exec(core_flags_pkg::OP_ADD, 8'hFF, 8'h01, 3'h0, 1'b0, 8'h00, 8'h1F);
      print_verdict();
   end
endmodule // testbench
